// ===== scsi_pio_pkg.sv
package scsi_pio_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_XFER_CTRL_0 = 8'h04;
  localparam logic [7:0] ADDR_XFER_CTRL_1 = 8'h08;
  localparam logic [7:0] ADDR_HOST_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS_0 = 8'h10;
  localparam logic [7:0] ADDR_STATUS_1 = 8'h14;
  localparam logic [7:0] ADDR_DATA_LATCH_LOW = 8'h18;
  localparam logic [7:0] ADDR_DATA_LATCH_HIGH = 8'h1c;
  localparam logic [7:0] ADDR_SIGNAL_OUT = 8'h20;
  localparam logic [7:0] ADDR_SIGNAL_IN = 8'h24;
  localparam logic [7:0] ADDR_LIVE_BUS_LOW = 8'h28;
  localparam logic [7:0] ADDR_OWN_ID = 8'h2c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h30;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_TERM_POLARITY = 1;
  localparam int BIT_TERM_ENABLE = 0;
  localparam int BIT_AUTO_PIO_ENABLE = 3;
  localparam int BIT_SOFT_CHIP_RESET = 0;
  localparam int BIT_SEQ_PAUSE = 2;
  localparam int BIT_PIO_READY = 1;
  localparam int BIT_PHASE_MISMATCH = 4;
  localparam int BIT_BUS_FREE = 0;
  localparam int BIT_INT_PIO = 0;
  localparam int BIT_SIG_ACK = 0;
  localparam int BIT_SIG_BSY = 2;
  localparam int BIT_SIG_SEL = 3;
  localparam int BIT_SIG_ATN = 4;
  localparam int PHASE_LSB = 5;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_HOST_CONTROL = 8'h04;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DATA_SETUP_NS = 40;
  localparam int DATA_SETUP_CYCLES_RAW =
    (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_CYCLES =
    (DATA_SETUP_CYCLES_RAW < 1) ? 1 : DATA_SETUP_CYCLES_RAW;
  localparam logic [1:0] SETUP_LAST = 2'(DATA_SETUP_CYCLES - 1);

  typedef enum logic [1:0] {
    PIO_IDLE,
    PIO_WAIT_HOST,
    PIO_SETUP,
    PIO_ACK
  } pio_state_t;
endpackage : scsi_pio_pkg

// ===== scsi_pio_term.sv
`timescale 1ns/1ps
`default_nettype none
module scsi_pio_term
  import scsi_pio_pkg::*;
(
  input wire logic clock_in,              // 25 MHz clock
  input wire logic reset_in,              // sync reset, active high
  input wire logic bus_reset_n_in,        // chip reset pin, active low
  input wire logic psel_in,               // apb select
  input wire logic penable_in,            // apb enable
  input wire logic pwrite_in,             // apb write
  input wire logic [7:0] paddr_in,        // apb byte address
  input wire logic [31:0] pwdata_in,      // apb write data
  output logic [31:0] prdata_out,         // apb read data
  output logic pready_out,                // apb ready
  output logic pslverr_out,               // apb error, unmapped
  input wire logic [7:0] data_in,         // scsi data lines in
  output logic [7:0] data_out,            // scsi data lines out
  output logic data_oe_out,               // scsi data drive enable
  input wire logic req_in,                // scsi req, asserted high
  input wire logic ack_in,                // scsi ack as seen on bus
  input wire logic cd_in,                 // scsi c/d
  input wire logic io_in,                 // scsi i/o, 1 = in
  input wire logic msg_in,                // scsi msg
  input wire logic atn_in,                // scsi atn as seen
  input wire logic sel_in,                // scsi sel as seen
  input wire logic bsy_in,                // scsi bsy as seen
  output logic ack_out,                   // scsi ack drive
  output logic atn_out,                   // scsi atn drive
  output logic sel_out,                   // scsi sel drive
  output logic bsy_out,                   // scsi bsy drive
  output logic term_power_out,            // termination power level
  output logic term_power_oe_out,         // termination power enable
  output logic seq_pause_out,             // sequencer pause request
  output logic pio_irq_out                // pio ready interrupt
);
  // ----------------------------------------------------------------
  // reset and apb decode
  // ----------------------------------------------------------------
  logic rst, apb_setup, wr_en, rd_en, soft_chip_reset, latch_wr, latch_rd;
  assign rst = reset_in || !bus_reset_n_in;
  assign apb_setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pready_out && pwrite_in;
  assign rd_en = psel_in && penable_in && pready_out && !pwrite_in;
  assign soft_chip_reset = wr_en && (paddr_in == ADDR_HOST_CONTROL) &&
                           pwdata_in[BIT_SOFT_CHIP_RESET];
  assign latch_wr = wr_en && (paddr_in == ADDR_DATA_LATCH_LOW);
  assign latch_rd = rd_en && (paddr_in == ADDR_DATA_LATCH_LOW);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] device_config_reg, xfer_ctrl_0, xfer_ctrl_1;
  logic [7:0] host_control_reg, data_latch_low, data_latch_high;
  logic [7:0] signal_out_reg, own_id, int_mask;
  logic term_ever_enabled, bus_free, pio_ready, auto_ack, auto_drive;
  logic [1:0] setup_cnt;
  pio_state_t state;
  logic req_meta, req_sync, ack_meta, ack_sync;
  logic auto_on, phase_mismatch;

  assign auto_on = xfer_ctrl_0[BIT_AUTO_PIO_ENABLE];
  assign phase_mismatch =
    signal_out_reg[PHASE_LSB +: 3] != {cd_in, io_in, msg_in};

  // polarity cleared only by the pin or reset, never by soft reset
  always_ff @(posedge clock_in) begin
    if (rst) begin
      device_config_reg <= RST_REG;
    end else if (wr_en && paddr_in == ADDR_DEVICE_CONFIG) begin
      device_config_reg <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      xfer_ctrl_1 <= RST_REG;
    end else if (soft_chip_reset) begin
      xfer_ctrl_1[BIT_TERM_ENABLE] <= 1'b0;
    end else if (wr_en && paddr_in == ADDR_XFER_CTRL_1) begin
      xfer_ctrl_1 <= pwdata_in[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      term_ever_enabled <= 1'b0;
    end else if (wr_en && paddr_in == ADDR_XFER_CTRL_1 &&
                 pwdata_in[BIT_TERM_ENABLE]) begin
      term_ever_enabled <= 1'b1;
    end
  end

  // automatic modes off, interrupts masked, sequencer paused after reset
  always_ff @(posedge clock_in) begin
    if (rst) begin
      xfer_ctrl_0 <= RST_REG;
      host_control_reg <= RST_HOST_CONTROL;
      int_mask <= RST_REG;
      own_id <= RST_REG;
      signal_out_reg <= RST_REG;
      data_latch_high <= RST_REG;
    end else if (wr_en) begin
      case (paddr_in)
        ADDR_XFER_CTRL_0: xfer_ctrl_0 <= pwdata_in[7:0];
        ADDR_HOST_CONTROL: begin
          host_control_reg <= pwdata_in[7:0] &
                              ~(8'h01 << BIT_SOFT_CHIP_RESET);
        end
        ADDR_INT_MASK: int_mask <= pwdata_in[7:0];
        ADDR_OWN_ID: own_id <= pwdata_in[7:0];
        ADDR_SIGNAL_OUT: signal_out_reg <= pwdata_in[7:0];
        ADDR_DATA_LATCH_HIGH: data_latch_high <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers and bus free
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (rst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      req_meta <= req_in;
      req_sync <= req_meta;
      ack_meta <= ack_in;
      ack_sync <= ack_meta;
    end
  end

  // a free bus seen in the same cycle as a clear keeps the bit set
  always_ff @(posedge clock_in) begin
    if (rst) begin
      bus_free <= 1'b0;
    end else if (!bsy_in && !sel_in) begin
      bus_free <= 1'b1;
    end else if (wr_en && paddr_in == ADDR_STATUS_1 &&
                 pwdata_in[BIT_BUS_FREE]) begin
      bus_free <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // automatic pio handshake
  // ----------------------------------------------------------------
  // idle waits for matched phase; manual mode leaves this at rest
  always_ff @(posedge clock_in) begin
    if (rst || soft_chip_reset) begin
      state <= PIO_IDLE;
      pio_ready <= 1'b0;
      auto_ack <= 1'b0;
      auto_drive <= 1'b0;
      setup_cnt <= 2'h0;
    end else begin
      case (state)
        PIO_IDLE: begin
          auto_ack <= 1'b0;
          auto_drive <= 1'b0;
          if (auto_on && !phase_mismatch && req_sync) begin
            pio_ready <= 1'b1;
            state <= PIO_WAIT_HOST;
          end
        end
        PIO_WAIT_HOST: begin
          if (!auto_on) begin
            pio_ready <= 1'b0;
            state <= PIO_IDLE;
          end else if (!io_in && latch_wr) begin
            pio_ready <= 1'b0;
            auto_drive <= 1'b1;
            setup_cnt <= 2'h0;
            state <= PIO_SETUP;
          end else if (io_in && latch_rd) begin
            pio_ready <= 1'b0;
            auto_ack <= 1'b1;
            state <= PIO_ACK;
          end
        end
        PIO_SETUP: begin
          if (setup_cnt == SETUP_LAST) begin
            auto_ack <= 1'b1;
            state <= PIO_ACK;
          end else begin
            setup_cnt <= setup_cnt + 2'h1;
          end
        end
        PIO_ACK: begin
          if (!req_sync) begin
            auto_ack <= 1'b0;
            auto_drive <= 1'b0;
            state <= PIO_IDLE;
          end
        end
        default: state <= PIO_IDLE;
      endcase
    end
  end

  // in direction takes the bus byte as ready rises; else host writes
  always_ff @(posedge clock_in) begin
    if (rst) begin
      data_latch_low <= RST_REG;
    end else if (state == PIO_IDLE && auto_on && !phase_mismatch &&
                 req_sync && io_in) begin
      data_latch_low <= data_in;
    end else if (latch_wr) begin
      data_latch_low <= pwdata_in[7:0];
    end
  end

  // ----------------------------------------------------------------
  // apb read path, answered in the access cycle
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (paddr_in)
      ADDR_DEVICE_CONFIG: rd_byte = device_config_reg;
      ADDR_XFER_CTRL_0: rd_byte = xfer_ctrl_0;
      ADDR_XFER_CTRL_1: rd_byte = xfer_ctrl_1;
      ADDR_HOST_CONTROL: rd_byte = host_control_reg;
      ADDR_STATUS_0: rd_byte = 8'(pio_ready) << BIT_PIO_READY;
      ADDR_STATUS_1: begin
        rd_byte = (8'(phase_mismatch) << BIT_PHASE_MISMATCH) |
                  (8'(bus_free) << BIT_BUS_FREE);
      end
      ADDR_DATA_LATCH_LOW: rd_byte = data_latch_low;
      ADDR_DATA_LATCH_HIGH: rd_byte = data_latch_high;
      ADDR_SIGNAL_OUT: rd_byte = signal_out_reg;
      ADDR_SIGNAL_IN: begin
        rd_byte = {cd_in, io_in, msg_in, atn_in, sel_in, bsy_in,
                   req_sync, ack_sync};
      end
      ADDR_LIVE_BUS_LOW: rd_byte = data_in;
      ADDR_OWN_ID: rd_byte = own_id;
      ADDR_INT_MASK: rd_byte = int_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      pready_out <= apb_setup;
      pslverr_out <= apb_setup && !rd_hit;
      if (apb_setup) begin
        prdata_out <= {24'h0, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // bus and pin outputs
  // ----------------------------------------------------------------
  // manual data drive only in out direction while bsy is seen on the bus, from any device
  always_ff @(posedge clock_in) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe_out <= 1'b0;
      ack_out <= 1'b0;
      atn_out <= 1'b0;
      sel_out <= 1'b0;
      bsy_out <= 1'b0;
      seq_pause_out <= 1'b1;
      pio_irq_out <= 1'b0;
    end else begin
      data_out <= data_latch_low;
      data_oe_out <= auto_drive || (!auto_on && !io_in && bsy_in);
      ack_out <= auto_ack ||
                 (!auto_on && signal_out_reg[BIT_SIG_ACK]);
      atn_out <= signal_out_reg[BIT_SIG_ATN];
      sel_out <= signal_out_reg[BIT_SIG_SEL];
      bsy_out <= signal_out_reg[BIT_SIG_BSY];
      seq_pause_out <= host_control_reg[BIT_SEQ_PAUSE];
      pio_irq_out <= pio_ready && int_mask[BIT_INT_PIO];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst) begin
      term_power_out <= 1'b0;
      term_power_oe_out <= 1'b0;
    end else begin
      term_power_out <= xfer_ctrl_1[BIT_TERM_ENABLE] ^
                        device_config_reg[BIT_TERM_POLARITY];
      term_power_oe_out <= term_ever_enabled;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_TERM_FLOATS_IN_RESET: assert property (
    @(posedge clock_in) disable iff (reset_in)
    !bus_reset_n_in |=> !term_power_oe_out && !xfer_ctrl_1[0] &&
                        !device_config_reg[1])
    else $error("termination pin not floated by bus reset");
  AST_TERM_LEVEL: assert property (
    @(posedge clock_in) disable iff (rst)
    $past(!rst) |-> term_power_out ==
      ($past(xfer_ctrl_1[0]) ^ $past(device_config_reg[1])))
    else $error("termination level wrong for enable and polarity");
  AST_TERM_STAYS_DRIVEN: assert property (
    @(posedge clock_in) disable iff (rst)
    term_power_oe_out |=> term_power_oe_out)
    else $error("termination pin released without reset");
  AST_SOFT_RESET_TERM: assert property (
    @(posedge clock_in) disable iff (rst)
    soft_chip_reset |=> !xfer_ctrl_1[0] &&
      device_config_reg == $past(device_config_reg) ##1 term_power_out ==
      device_config_reg[1])
    else $error("soft reset did not leave pin inactive");
  AST_READY_CAUSE: assert property (
    @(posedge clock_in) disable iff (rst)
    $rose(pio_ready) |-> $past(auto_on && !phase_mismatch && req_sync))
    else $error("ready set without enable, match and req");
  AST_OUT_WRITE_ACK: assert property (
    @(posedge clock_in) disable iff (rst)
    state == PIO_WAIT_HOST && auto_on && !io_in && latch_wr |=>
      !pio_ready ##1 data_oe_out ##[1:3] ack_out)
    else $error("out write did not drive data then ack");
  AST_ACK_RELEASE: assert property (
    @(posedge clock_in) disable iff (rst)
    state == PIO_ACK && !req_sync |=> !auto_ack ##1 !ack_out)
    else $error("ack not released after req fell");
  AST_IN_CAPTURE: assert property (
    @(posedge clock_in) disable iff (rst)
    state == PIO_IDLE && auto_on && !phase_mismatch && req_sync && io_in
      |=> pio_ready && data_latch_low == $past(data_in))
    else $error("in byte not captured with ready");
  AST_IN_READ_ACK: assert property (
    @(posedge clock_in) disable iff (rst)
    state == PIO_WAIT_HOST && auto_on && io_in && latch_rd |=>
      !pio_ready && auto_ack ##1 ack_out)
    else $error("in read did not ack");
  AST_PAUSED_AFTER_RESET: assert property (
    @(posedge clock_in) disable iff (rst)
    $past(rst) |-> seq_pause_out && !pio_irq_out && !auto_on)
    else $error("not paused with automatics off after reset");
  AST_IRQ_FOLLOWS_READY: assert property (
    @(posedge clock_in) disable iff (rst)
    $past(!rst) |-> pio_irq_out == $past(pio_ready && int_mask[0]))
    else $error("pio interrupt does not follow ready");
  AST_BUS_FREE: assert property (
    @(posedge clock_in) disable iff (rst)
    !bsy_in && !sel_in |=> bus_free)
    else $error("bus free status not set");
  AST_REQ_SYNC: assert property (
    @(posedge clock_in) disable iff (rst)
    $rose(req_in) ##1 req_in |=> req_sync)
    else $error("req synchroniser latency wrong");
endmodule : scsi_pio_term
`default_nettype wire

// ===== scsi_target_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far-side target for pio handshakes
// ----------------------------------------
module scsi_target_model (
  input wire logic clock_in,          // bus clock
  input wire logic ack_in,            // ack seen on bus
  input wire logic [7:0] dev_data_in, // initiator data
  input wire logic dev_oe_in,         // initiator drives data
  output logic [7:0] bus_out,         // resolved data lines
  output logic req_out,               // req drive
  output logic io_out,                // i/o phase line
  output logic bsy_out                // bsy drive
);
  logic drive = 1'b0;
  logic [7:0] val = 8'h00;
  logic [7:0] noise = 8'h69;
  // released lines wander so a stale byte never passes for data
  always_ff @(posedge clock_in) noise <= ~noise;
  assign bus_out = dev_oe_in ? dev_data_in : (drive ? val : noise);
  initial begin
    req_out = 1'b0;
    io_out = 1'b0;
    bsy_out = 1'b0;
  end
  task automatic xfer(input logic dir, input logic [7:0] v, input int lim,
                      output logic [7:0] got, output logic ok);
    int n;
    @(posedge clock_in);
    io_out <= dir;
    bsy_out <= 1'b1;
    drive <= dir;
    val <= v;
    @(posedge clock_in);
    req_out <= 1'b1;
    n = 0;
    while (ack_in !== 1'b1 && n < lim) begin
      @(posedge clock_in);
      n++;
    end
    ok = (n < lim);
    got = bus_out;
    @(posedge clock_in);
    req_out <= 1'b0;
    n = 0;
    while (ack_in !== 1'b0 && n < 50) begin
      @(posedge clock_in);
      n++;
    end
    ok = ok && (n < 50);
    drive <= 1'b0;
  endtask : xfer
endmodule : scsi_target_model
`default_nettype wire

// ===== scsi_pio_term_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scsi_pio_term_tb;
  import scsi_pio_pkg::*;
  logic clock_in, reset_in, bus_reset_n_in, psel, penable, pwrite;
  logic [7:0] paddr, bus, dout, got;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, ack, atn, sel, bsy, tbsy, req, io, dev_oe;
  logic pw_lvl, pw_oe, pause, irq, e, ok;
  int bad_count = 0;
  int num_checks = 0;
  scsi_pio_term DUT (.clock_in(clock_in), .reset_in(reset_in),
    .bus_reset_n_in(bus_reset_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .data_in(bus), .data_out(dout), .data_oe_out(dev_oe), .req_in(req),
    .ack_in(ack), .cd_in(1'b0), .io_in(io), .msg_in(1'b0), .atn_in(atn),
    .sel_in(sel), .bsy_in(bsy | tbsy), .ack_out(ack), .atn_out(atn),
    .sel_out(sel), .bsy_out(bsy), .term_power_out(pw_lvl),
    .term_power_oe_out(pw_oe), .seq_pause_out(pause), .pio_irq_out(irq));
  scsi_target_model tgt (.clock_in(clock_in), .ack_in(ack),
    .dev_data_in(dout), .dev_oe_in(dev_oe), .bus_out(bus), .req_out(req),
    .io_out(io), .bsy_out(tbsy));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task check(input string nm, input logic [31:0] seen, input logic [31:0] x);
    num_checks++;
    if (seen !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, x, seen);
    end
  endtask : check
  // ----------------------------------------
  // apb master, waits for pready
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input string nm, input logic [7:0] a, input logic [31:0] m,
          input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(nm, r & m, x);
  endtask : rd
  // level is masked while floating, its value is then meaningless
  task pin(input logic oe_x, input logic lvl_x);
    repeat (2) @(posedge clock_in);
    check("term pin", {30'h0, pw_oe, pw_oe & pw_lvl}, {30'h0, oe_x, lvl_x});
  endtask : pin
  task poll(input logic x);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS_0, 32'h0);
      n++;
    end while (r[BIT_PIO_READY] !== x && n < 30);
    check("pio ready", {31'h0, r[BIT_PIO_READY]}, {31'h0, x});
  endtask : poll
  task bus_rst();
    bus_reset_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    bus_reset_n_in <= 1'b1;
  endtask : bus_rst
  initial begin
    reset_in = 1'b1;
    bus_reset_n_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clock_in);
    reset_in <= 1'b0;
    rd("host ctl", ADDR_HOST_CONTROL, 32'hff, 32'(RST_HOST_CONTROL));
    check("pause", {31'h0, pause}, 32'h1);
    rd("auto pio", ADDR_XFER_CTRL_0, 32'h08, 32'h0);
    rd("int mask", ADDR_INT_MASK, 32'hff, 32'h0);
    rd("status 1", ADDR_STATUS_1, 32'h11, 32'h01);
    rd("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    check("slverr", {31'h0, e}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      bus_rst();
      pin(1'b0, 1'b0);
      rd("polarity", ADDR_DEVICE_CONFIG, 32'h02, 32'h0);
      wr(ADDR_DEVICE_CONFIG, 32'(p << 1));
      pin(1'b0, 1'b0);
      wr(ADDR_XFER_CTRL_1, 32'h1);
      pin(1'b1, p == 0);
      wr(ADDR_XFER_CTRL_1, 32'h0);
      pin(1'b1, p == 1);
      wr(ADDR_XFER_CTRL_1, 32'h1);
      wr(ADDR_HOST_CONTROL, 32'h05);
      pin(1'b1, p == 1);
      rd("enable", ADDR_XFER_CTRL_1, 32'h1, 32'h0);
      rd("polarity", ADDR_DEVICE_CONFIG, 32'h2, 32'(p << 1));
    end
    bus_rst();
    wr(ADDR_INT_MASK, 32'h1);
    wr(ADDR_XFER_CTRL_0, 32'h08);
    wr(ADDR_SIGNAL_OUT, 32'h0);
    fork
      tgt.xfer(1'b0, 8'h00, 200, got, ok);
      begin
        poll(1'b1);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_DATA_LATCH_LOW, 32'ha5);
        poll(1'b0);
        check("irq", {31'h0, irq}, 32'h0);
      end
    join
    check("out byte", {24'h0, got}, 32'ha5);
    check("out ack", {31'h0, ok}, 32'h1);
    check("released", {30'h0, ack, dev_oe}, 32'h0);
    wr(ADDR_SIGNAL_OUT, 32'h40);
    fork
      tgt.xfer(1'b1, 8'h3c, 200, got, ok);
      begin
        poll(1'b1);
        rd("live bus", ADDR_LIVE_BUS_LOW, 32'hff, 32'h3c);
        rd("in byte", ADDR_DATA_LATCH_LOW, 32'hff, 32'h3c);
        poll(1'b0);
      end
    join
    check("in ack", {31'h0, ok}, 32'h1);
    wr(ADDR_SIGNAL_OUT, 32'h0);
    fork
      tgt.xfer(1'b1, 8'h77, 40, got, ok);
      begin
        repeat (6) @(posedge clock_in);
        rd("mismatch", ADDR_STATUS_1, 32'h10, 32'h10);
        rd("held", ADDR_STATUS_0, 32'h02, 32'h0);
      end
    join
    check("no ack", {31'h0, ok}, 32'h0);
    wr(ADDR_XFER_CTRL_0, 32'h0);
    wr(ADDR_SIGNAL_OUT, 32'h40);
    fork
      tgt.xfer(1'b1, 8'h77, 40, got, ok);
      begin
        repeat (6) @(posedge clock_in);
        rd("auto off", ADDR_STATUS_0, 32'h02, 32'h0);
      end
    join
    check("no ack", {31'h0, ok}, 32'h0);
    wr(ADDR_SIGNAL_OUT, 32'h5d);
    repeat (2) @(posedge clock_in);
    check("manual ack", {31'h0, ack}, 32'h1);
    check("manual lines", {29'h0, atn, sel, bsy}, 32'h7);
    rd("signal in", ADDR_SIGNAL_IN, 32'hff, 32'h5d);
    wr(ADDR_DATA_LATCH_HIGH, 32'h5a);
    rd("latch high", ADDR_DATA_LATCH_HIGH, 32'hff, 32'h5a);
    wr(ADDR_SIGNAL_OUT, 32'h40);
    repeat (2) @(posedge clock_in);
    check("manual ack", {31'h0, ack}, 32'h0);
    finish_test();
  end
endmodule : scsi_pio_term_tb
`default_nettype wire
